// file: hw/coproc_alu_byte_field_ops.sv
// Summary of operation
// - add-high adds constant:00 into destination
// - 16-bit results: n=bit15, z=all zero
// - add-high overflow from signs old/const/new
// - add-high carry out of bit 15
// - field width/offset from source2, xnor insert
// - bits outside field stay unchanged
// - field bits above 15 dropped, no wrap
// - zero register source toggles field bits
// - insert and xnor-low: v cleared, c kept
// - xnor-low: complement of low byte xor
// - xnor-low keeps destination high byte
`timescale 1ns/10ps
`default_nettype none

module coproc_alu_byte_field_ops
  import coproc_alu_pkg::*;
#(
  parameter int NUM_REGS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // instruction issue from the decoder
  input wire logic issue_valid,
  input wire alu_issue_t issue,
  // register file preload port
  input wire logic load_valid,
  input wire logic [IDX_W-1:0] load_idx,
  input wire logic [DATA_W-1:0] load_data,
  // register file read port
  input wire logic [IDX_W-1:0] read_idx,
  output logic [DATA_W-1:0] read_data_r,
  // execution result
  output logic done_r,
  output logic [IDX_W-1:0] result_idx_r,
  output logic [DATA_W-1:0] result_r,
  output condition_flags_t flags_r
);

  // =============================================================
  // register file
  // =============================================================
  // entry 0 is never written; it exists only to keep indexing plain
  logic [DATA_W-1:0] regs_r [NUM_REGS];
  // operand values as seen by the datapath
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] s1_val;
  logic [DATA_W-1:0] s2_val;
  // a real instruction is being executed this cycle
  logic exec;
  // next result and flags
  logic [DATA_W-1:0] result_nxt;
  condition_flags_t flags_nxt;

  assign exec = issue_valid && (issue.op != OP_NONE);

  // operand reads: zero register forced to zero on every port
  assign rd_val = (issue.dest_idx == ZERO_REG_IDX) ? WORD_ZERO
                  : regs_r[issue.dest_idx];
  assign s1_val = (issue.src1_idx == ZERO_REG_IDX) ? WORD_ZERO
                  : regs_r[issue.src1_idx];
  assign s2_val = (issue.src2_idx == ZERO_REG_IDX) ? WORD_ZERO
                  : regs_r[issue.src2_idx];

  // one write process per entry; execution beats a preload
  // to the same entry, since the decoder owns ordering
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(g);
      if (g == 0) begin : g_zero
        // constant zero entry, writes are discarded
        always_ff @(posedge mclk) begin
          regs_r[g] <= WORD_ZERO;
        end
      end else begin : g_gen
        // general purpose entry
        always_ff @(posedge mclk) begin
          if (sys_rst) begin
            regs_r[g] <= WORD_ZERO;
          end else if (exec && issue.dest_idx == MY_IDX) begin
            regs_r[g] <= result_nxt;
          end else if (load_valid && load_idx == MY_IDX) begin
            regs_r[g] <= load_data;
          end
        end
      end
    end
  endgenerate

  // registered read port
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      read_data_r <= WORD_ZERO;
    end else if (read_idx == ZERO_REG_IDX) begin
      read_data_r <= WORD_ZERO;
    end else begin
      read_data_r <= regs_r[read_idx];
    end
  end

  // =============================================================
  // arithmetic and logic units
  // =============================================================
  // 17-bit sum keeps the carry out of bit 15
  logic [DATA_W:0] sum_w;
  // field descriptor
  logic [3:0] fw;
  logic [3:0] fo;
  logic [DATA_W-1:0] fld_mask;
  logic [DATA_W-1:0] fld_res;
  // low byte xnor
  logic [7:0] xl_res;

  // constant sits in the upper byte, lower byte zero
  assign sum_w = {1'b0, rd_val} + {1'b0, issue.byte_constant, BYTE_ZERO};

  // width and offset come straight from the second source
  assign fw = s2_val[W_HI:W_LO];
  assign fo = s2_val[O_HI:O_LO];
  // mask truncation drops anything shifted past bit 15
  assign fld_mask = field_mask(fw, fo);
  // source bits shifted to the offset, xnor only inside the mask
  assign fld_res = (rd_val & ~fld_mask)
                   | (~((s1_val << fo) ^ rd_val) & fld_mask);

  // with a zero source the xnor is plain inversion, so toggles
  // come for free without a dedicated path
  assign xl_res = ~(rd_val[7:0] ^ issue.byte_constant);

  // =============================================================
  // result and flag selection
  // =============================================================
  // flags hold unless the operation defines them
  always_comb begin
    flags_nxt = flags_r;
    result_nxt = rd_val;
    case (issue.op)
      OP_ADD_IMMEDIATE_HIGH: begin
        result_nxt = sum_w[DATA_W-1:0];
        flags_nxt.n = sum_w[SIGN_BIT];
        flags_nxt.z = (sum_w[DATA_W-1:0] == WORD_ZERO);
        // overflow only when both addends agree and the sum differs
        flags_nxt.v = (rd_val[SIGN_BIT] == issue.byte_constant[BYTE_SIGN_BIT])
                      && (sum_w[SIGN_BIT] != rd_val[SIGN_BIT]);
        flags_nxt.c = sum_w[DATA_W];
      end
      OP_FIELD_INSERT_XNOR: begin
        result_nxt = fld_res;
        flags_nxt.n = fld_res[SIGN_BIT];
        flags_nxt.z = (fld_res == WORD_ZERO);
        flags_nxt.v = 1'b0;
      end
      OP_XNOR_IMMEDIATE_LOW: begin
        result_nxt = {rd_val[DATA_W-1:8], xl_res};
        flags_nxt.n = xl_res[BYTE_SIGN_BIT];
        flags_nxt.z = (xl_res == BYTE_ZERO);
        flags_nxt.v = 1'b0;
      end
      default: begin
        // idle slot, nothing changes
      end
    endcase
  end

  // =============================================================
  // output registers
  // =============================================================
  // completion strobe, one cycle per executed instruction
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= exec;
    end
  end

  // result word and destination index, held until next exec
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_r <= WORD_ZERO;
      result_idx_r <= ZERO_REG_IDX;
    end else if (exec) begin
      result_r <= result_nxt;
      result_idx_r <= issue.dest_idx;
    end
  end

  // condition flags; carry is kept by insert and xnor-low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else if (exec) begin
      flags_r <= flags_nxt;
    end
  end

  // =============================================================
  // assertions
  // =============================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // issue sequences, one per operation, plus one for the 16-bit result operations
  sequence add_issue_s;
    exec && issue.op == OP_ADD_IMMEDIATE_HIGH;
  endsequence
  sequence fld_issue_s;
    exec && issue.op == OP_FIELD_INSERT_XNOR;
  endsequence
  sequence xnl_issue_s;
    exec && issue.op == OP_XNOR_IMMEDIATE_LOW;
  endsequence
  sequence word_issue_s;
    exec && issue.op != OP_XNOR_IMMEDIATE_LOW;
  endsequence

  add_high_sum_a: assert property (
    add_issue_s |=> done_r
      && result_r == $past(rd_val) + {$past(issue.byte_constant), BYTE_ZERO})
    else $error("add-high sum wrong");

  word_nz_flags_a: assert property (
    word_issue_s |=> flags_r.n == result_r[SIGN_BIT]
      && flags_r.z == (result_r == WORD_ZERO))
    else $error("16-bit n or z flag wrong");

  add_overflow_a: assert property (
    add_issue_s |=> flags_r.v == (
      ($past(rd_val[SIGN_BIT]) == $past(issue.byte_constant[BYTE_SIGN_BIT]))
      && (result_r[SIGN_BIT] != $past(rd_val[SIGN_BIT]))))
    else $error("add-high overflow wrong");

  add_carry_a: assert property (
    add_issue_s |=> flags_r.c == (result_r < $past(rd_val)))
    else $error("add-high carry wrong");

  field_xnor_a: assert property (
    fld_issue_s |=> ((result_r
      ^ ~(($past(s1_val) << $past(fo)) ^ $past(rd_val)))
      & field_mask($past(fw), $past(fo))) == WORD_ZERO)
    else $error("field insert bits wrong");

  field_outside_a: assert property (
    fld_issue_s |=> ((result_r ^ $past(rd_val))
      & ~field_mask($past(fw), $past(fo))) == WORD_ZERO)
    else $error("bits outside field changed");

  field_nowrap_a: assert property (
    fld_issue_s ##0 ({1'b0, fo} + {1'b0, fw} > FIELD_LIMIT)
      |=> ((result_r ^ $past(rd_val))
      & ((16'h0001 << $past(fo)) - 16'h0001)) == WORD_ZERO)
    else $error("field wrapped below offset");

  field_toggle_a: assert property (
    fld_issue_s ##0 (issue.src1_idx == ZERO_REG_IDX)
      |=> result_r == ($past(rd_val) ^ field_mask($past(fw), $past(fo))))
    else $error("zero source did not toggle");

  logic_vc_flags_a: assert property (
    (fld_issue_s or xnl_issue_s) |=> !flags_r.v
      && flags_r.c == $past(flags_r.c))
    else $error("v not cleared or c changed");

  xnor_low_byte_a: assert property (
    xnl_issue_s |=> result_r[7:0]
      == ~($past(rd_val[7:0]) ^ $past(issue.byte_constant)))
    else $error("xnor-low byte wrong");

  xnor_high_keep_a: assert property (
    xnl_issue_s |=> result_r[DATA_W-1:8] == $past(rd_val[DATA_W-1:8]))
    else $error("xnor-low changed high byte");

  xnor_low_flags_a: assert property (
    xnl_issue_s |=> flags_r.n == result_r[BYTE_SIGN_BIT]
      && flags_r.z == (result_r[7:0] == BYTE_ZERO))
    else $error("xnor-low n or z wrong");

  zero_reg_read_a: assert property (
    (read_idx == ZERO_REG_IDX) |=> read_data_r == WORD_ZERO)
    else $error("zero register read nonzero");

  // every executed issue gives one strobe naming its destination
  done_index_a: assert property (
    exec |=> done_r && result_idx_r == $past(issue.dest_idx))
    else $error("done strobe or result index wrong");

  // stored entry must match the reported result, else a dependent
  // issue in the next slot would read a stale operand
  reg_writeback_a: assert property (
    exec && issue.dest_idx != ZERO_REG_IDX
      |=> regs_r[result_idx_r] == result_r)
    else $error("result not written back");

  // idle or no-op slots leave result and flags alone and drop the strobe
  idle_hold_a: assert property (
    !exec |=> !done_r && $stable(result_r) && $stable(flags_r))
    else $error("outputs moved without an issue");

  // entry 0 itself never leaves zero, whatever is aimed at it
  zero_entry_a: assert property (
    regs_r[ZERO_REG_IDX] == WORD_ZERO)
    else $error("zero register entry written");

endmodule : coproc_alu_byte_field_ops

`default_nettype wire

// file: hw/coproc_alu_pkg.sv
// =============================================================
// shared constants and types of the coprocessor alu slice
// =============================================================
package coproc_alu_pkg;
  // datapath geometry
  localparam int DATA_W = 16;
  localparam int IDX_W = 3;
  localparam int SIGN_BIT = 15;
  localparam int BYTE_SIGN_BIT = 7;
  // field descriptor layout inside the second source
  localparam int W_HI = 7;
  localparam int W_LO = 4;
  localparam int O_HI = 3;
  localparam int O_LO = 0;
  // highest legal offset plus width before bits fall off the top
  localparam logic [4:0] FIELD_LIMIT = 5'h0f;
  // constant operands and reset values
  localparam logic [IDX_W-1:0] ZERO_REG_IDX = 3'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // operation select from the decoder
  typedef enum logic [1:0] {
    OP_ADD_IMMEDIATE_HIGH = 2'b00,
    OP_FIELD_INSERT_XNOR  = 2'b01,
    OP_XNOR_IMMEDIATE_LOW = 2'b10,
    OP_NONE               = 2'b11
  } alu_op_t;

  // condition_flags: negative, zero, overflow, carry
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } condition_flags_t;

  // one instruction as handed over by the decoder
  typedef struct packed {
    alu_op_t op;
    logic [IDX_W-1:0] dest_idx;
    logic [IDX_W-1:0] src1_idx;
    logic [IDX_W-1:0] src2_idx;
    logic [7:0] byte_constant;
  } alu_issue_t;

  // field mask: w+1 ones at offset o, bits past 15 simply dropped
  function automatic logic [DATA_W-1:0] field_mask(input logic [3:0] w,
                                                   input logic [3:0] o);
    logic [31:0] m;
    m = ((32'h1 << (w + 5'h1)) - 32'h1) << o;
    return m[DATA_W-1:0];
  endfunction : field_mask
endpackage : coproc_alu_pkg

// file: testbench/decoder_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// decoder model: one issue per clock, never waits on a ready
// =====================================================
module decoder_model
  import coproc_alu_pkg::*;
(
  // clock
  input wire logic mclk,
  // issue toward the alu
  output logic issue_valid,
  output alu_issue_t issue
);
  // quiet from time zero until the bench asks for work
  initial begin
    issue_valid = 1'b0;
    issue = '0;
  end
  // present one instruction from the next rising edge on
  task automatic send(input alu_issue_t i);
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue <= i;
  endtask : send
  // drop valid; scramble the fields so a stale issue is never reused by luck
  task automatic idle();
    @(posedge mclk);
    issue_valid <= 1'b0;
    issue <= ~issue;
  endtask : idle
endmodule : decoder_model
`default_nettype wire

// file: testbench/coproc_alu_byte_field_ops_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// self-checking bench of the byte and field alu slice
// =====================================================
module coproc_alu_byte_field_ops_tb_top;
  import coproc_alu_pkg::*;
  logic mclk = 1'b0; // 100 MHz core clock
  logic sys_rst = 1'b1; // held for 8 cycles at start
  logic issue_valid; // from the decoder model
  alu_issue_t issue; // from the decoder model
  logic load_valid = 1'b0; // preload strobe
  logic [IDX_W-1:0] load_idx = 3'h0;
  logic [DATA_W-1:0] load_data = 16'h0000;
  logic [IDX_W-1:0] read_idx = 3'h0;
  logic [DATA_W-1:0] read_data_r;
  logic done_r;
  logic [IDX_W-1:0] result_idx_r;
  logic [DATA_W-1:0] result_r;
  condition_flags_t flags_r;
  int errors = 0; // mismatches seen
  int total_checks = 0; // comparisons made

  // free-running clock, half period 5 ns
  always #5 mclk = ~mclk;

  decoder_model u_decoder_model (.mclk(mclk), .issue_valid(issue_valid), .issue(issue));

  coproc_alu_byte_field_ops u_coproc_alu_byte_field_ops (
    .mclk(mclk), .sys_rst(sys_rst), .issue_valid(issue_valid), .issue(issue),
    .load_valid(load_valid), .load_idx(load_idx), .load_data(load_data),
    .read_idx(read_idx), .read_data_r(read_data_r), .done_r(done_r),
    .result_idx_r(result_idx_r), .result_r(result_r), .flags_r(flags_r)
  );

  // =====================================================
  // helpers
  // =====================================================
  // one comparison, four-state exact
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // flags packed n,z,v,c into the low nibble
  function automatic logic [15:0] fl(input logic n, z, v, c);
    return {12'h000, n, z, v, c};
  endfunction : fl
  function automatic alu_issue_t mk(input alu_op_t op, input logic [2:0] d, s1, s2,
                                    input logic [7:0] k);
    return '{op, d, s1, s2, k};
  endfunction : mk
  // preload one register; strobe dropped on the following edge
  task automatic load(input logic [2:0] idx, input logic [15:0] data);
    @(posedge mclk);
    load_valid <= 1'b1;
    load_idx <= idx;
    load_data <= data;
    @(posedge mclk);
    load_valid <= 1'b0;
  endtask : load
  // registered read, sampled after the edge that captures it
  task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
    @(posedge mclk);
    read_idx <= idx;
    @(posedge mclk);
    #1 chk("read_data_r", read_data_r, exp);
  endtask : rd
  // single issue, answer one cycle later
  task automatic exec(input alu_issue_t i, input logic [15:0] er, input logic [15:0] ef);
    u_decoder_model.send(i);
    u_decoder_model.idle();
    #1 chk("done_r", {15'h0, done_r}, 16'h0001);
    chk("result_r", result_r, er);
    chk("result_idx_r", {13'h0, result_idx_r}, {13'h0, i.dest_idx});
    chk("flags_r", {12'h000, flags_r}, ef);
  endtask : exec

  // =====================================================
  // scenarios
  // =====================================================
  task automatic t_reset();
    chk("result_r", result_r, WORD_ZERO);
    chk("flags_r", {12'h000, flags_r}, fl(0, 0, 0, 0));
    chk("done_r", {15'h0, done_r}, 16'h0000);
    rd(3'h5, WORD_ZERO);
  endtask : t_reset
  // back-to-back dependent add-high: overflow, then carry out to zero
  task automatic t_add_high();
    load(3'h2, 16'h7f00);
    u_decoder_model.send(mk(OP_ADD_IMMEDIATE_HIGH, 3'h2, 3'h0, 3'h0, 8'h01));
    u_decoder_model.send(mk(OP_ADD_IMMEDIATE_HIGH, 3'h2, 3'h0, 3'h0, 8'h80));
    #1 chk("result_r", result_r, 16'h8000);
    chk("flags_r", {12'h000, flags_r}, fl(1, 0, 1, 0));
    u_decoder_model.idle();
    #1 chk("result_r", result_r, 16'h0000);
    chk("flags_r", {12'h000, flags_r}, fl(0, 1, 1, 1));
    @(posedge mclk);
    #1 chk("done_r", {15'h0, done_r}, 16'h0000);
    // negative register plus positive constant: carry out, no overflow
    load(3'h3, 16'hff80);
    exec(mk(OP_ADD_IMMEDIATE_HIGH, 3'h3, 3'h0, 3'h0, 8'h01), 16'h0080, fl(0, 0, 0, 1));
  endtask : t_add_high
  // field insert in mid word, then a top field cut at bit 15 toggled via zero reg
  task automatic t_field();
    load(3'h4, 16'h00ff);
    load(3'h5, 16'h0001);
    load(3'h6, 16'h0013);
    exec(mk(OP_FIELD_INSERT_XNOR, 3'h4, 3'h5, 3'h6, 8'h00), 16'h00ef, fl(0, 0, 0, 1));
    load(3'h4, 16'h1234);
    load(3'h6, 16'h007c);
    exec(mk(OP_FIELD_INSERT_XNOR, 3'h4, 3'h0, 3'h6, 8'h00), 16'he234, fl(1, 0, 0, 1));
    rd(3'h4, 16'he234);
  endtask : t_field
  // xnor-low to zero byte, then to a negative byte, high byte kept
  task automatic t_xnor();
    load(3'h7, 16'h12ff);
    exec(mk(OP_XNOR_IMMEDIATE_LOW, 3'h7, 3'h0, 3'h0, 8'h00), 16'h1200, fl(0, 1, 0, 1));
    exec(mk(OP_XNOR_IMMEDIATE_LOW, 3'h7, 3'h0, 3'h0, 8'h7f), 16'h1280, fl(1, 0, 0, 1));
  endtask : t_xnor
  // no-op ignored; a write aimed at the zero register leaves it zero
  task automatic t_none_zero();
    u_decoder_model.send(mk(OP_NONE, 3'h3, 3'h1, 3'h1, 8'h55));
    u_decoder_model.idle();
    #1 chk("done_r", {15'h0, done_r}, 16'h0000);
    chk("result_r", result_r, 16'h1280);
    exec(mk(OP_ADD_IMMEDIATE_HIGH, ZERO_REG_IDX, 3'h0, 3'h0, 8'h01), 16'h0100, fl(0, 0, 0, 0));
    rd(ZERO_REG_IDX, WORD_ZERO);
  endtask : t_none_zero
  // reset in mid-run clears outputs, flags and a written register
  task automatic t_mid_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1 chk("result_r", result_r, WORD_ZERO);
    chk("flags_r", {12'h000, flags_r}, fl(0, 0, 0, 0));
    chk("done_r", {15'h0, done_r}, 16'h0000);
    rd(3'h7, WORD_ZERO);
  endtask : t_mid_reset

  // =====================================================
  // verdict and main sequence
  // =====================================================
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // whole run needs well under 200 cycles; 3000 means a hang
  initial begin
    #30000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1 t_reset();
    t_add_high();
    t_field();
    t_xnor();
    t_none_zero();
    t_mid_reset();
    stop_test();
  end
endmodule : coproc_alu_byte_field_ops_tb_top
`default_nettype wire
